// ### hw/cst_addr_add.sv
`timescale 1ns/10ps
module cst_addr_add #(
  parameter int W = 16
) (
  input  wire logic [W-1:0] base_in,
  input  wire logic [W-1:0] ofs_in,
  output logic      [W-1:0] sum_out
);
  // Wraps modulo 2**W like the address bus
  assign sum_out = base_in + ofs_in;
endmodule : cst_addr_add

// ### hw/cst_core.sv
// Notes on behaviour
// - Trap 83 bumps PC, pushes PC low, PC high, X, A, flags; 9 cycles.
// - After stacking trap sets mask, loads PC from vector, other flags kept.
// - Wait 8F clears mask only, issues in one cycle.
// - After wait, execution holds still until an interrupt request.
// - Test subtracts zero: V cleared, N and Z updated, H I C kept.
// - Test forms 3D/4D/5D/6D/7D/9E6D take 3/1/1/3/2/4 cycles.
// - 16-bit indexed offset: high byte first, added to index pair.
// - Extended address taken from two bytes, high byte first.
// - Offset8 post-increment: address is index pair plus offset, then pair increments.
// - Moves: direct to indexed+, indexed+ to direct, immediate to direct.
// - Bit test branch reads direct address then signed branch offset.
`timescale 1ns/10ps
`include "cst_cfg.svh"
module cst_core
  import cst_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [7:0]  mem_rdata_in,
  input  wire logic        irq_in,
  output logic      [15:0] mem_addr_out,
  output logic      [7:0]  mem_wdata_out,
  output logic             mem_we_out,
  output logic             opcode_strobe_out,
  output logic             halted_out,
  output logic      [7:0]  acc_out,
  output logic      [7:0]  x_out,
  output logic      [7:0]  h_out,
  output logic      [15:0] sp_out,
  output logic      [15:0] pc_out,
  output logic      [7:0]  ccr_out
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  cst_state_t  state,     next_state;
  logic [3:0]  step,      next_step;
  logic [7:0]  opc,       next_opc;
  logic        pre,       next_pre;
  logic [7:0]  tmp,       next_tmp;
  logic [7:0]  acc,       next_acc;
  logic [7:0]  xl,        next_xl;
  logic [7:0]  xh,        next_xh;
  logic [15:0] sp,        next_sp;
  logic [15:0] pc,        next_pc;
  logic [7:0]  flag_register,       next_ccr;
  logic [15:0] mem_addr,  next_mem_addr;
  logic [7:0]  mem_wdata, next_mem_wdata;
  logic        mem_we,    next_mem_we;
  logic        strobe,    next_strobe;
  logic        halted,    next_halted;
  logic        fin;
  logic        opf;
  logic        set_nz;
  logic        taken;
  logic [15:0] hx;
  logic [15:0] idx_sum;
  logic [15:0] br_sum;
  logic [7:0]  ofs_hi;
  logic [7:0]  nz_src;
  logic        nz_n;
  logic        nz_z;

  assign hx     = {xh, xl};
  assign ofs_hi = (opc == `CST_OP_LDA_OFS16) ? tmp : `CST_ZERO_PAGE;
  assign nz_src = (state == st_decode) ?
                  ((mem_rdata_in == `CST_OP_TEST_X) ? xl : acc) :
                  ((opc == `CST_OP_MOV_IMMD) ? tmp : mem_rdata_in);

  // ---------------------------------------------------------------
  // Address adders and zero test
  // ---------------------------------------------------------------
  cst_addr_add #(.W(16)) u_idx_add (
    .base_in (pre ? sp : hx),
    .ofs_in  ({ofs_hi, mem_rdata_in}),
    .sum_out (idx_sum)
  );

  cst_addr_add #(.W(16)) u_br_add (
    .base_in (pc),
    .ofs_in  ({{8{mem_rdata_in[7]}}, mem_rdata_in}),
    .sum_out (br_sum)
  );

  cst_nz_flags #(.W(8)) u_nz (
    .val_in   (nz_src),
    .neg_out  (nz_n),
    .zero_out (nz_z)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_state     = state;
    next_step      = step;
    next_opc       = opc;
    next_pre       = pre;
    next_tmp       = tmp;
    next_acc       = acc;
    next_xl        = xl;
    next_xh        = xh;
    next_sp        = sp;
    next_pc        = pc;
    next_ccr       = flag_register;
    next_mem_addr  = mem_addr;
    next_mem_wdata = mem_wdata;
    next_mem_we    = 1'b0;
    next_strobe    = 1'b0;
    next_halted    = halted;
    fin            = 1'b0;
    opf            = 1'b0;
    set_nz         = 1'b0;
    taken          = 1'b0;
    case (state)
      st_decode: begin
        next_opc  = mem_rdata_in;
        next_step = 4'd1;
        if (!pre && mem_rdata_in == `CST_OP_PREFIX) begin
          next_pre    = 1'b1;
          opf         = 1'b1;
          next_strobe = 1'b1;
        end else if (pre) begin
          if (mem_rdata_in == `CST_OP_TEST_IX1) begin
            opf        = 1'b1;
            next_state = st_exec;
          end else begin
            fin = 1'b1;
          end
        end else begin
          case (mem_rdata_in)
            `CST_OP_TEST_A, `CST_OP_TEST_X: begin
              set_nz = 1'b1;
              fin    = 1'b1;
            end
            `CST_OP_FLG2ACC: begin
              next_acc = flag_register;
              fin      = 1'b1;
            end
            `CST_OP_ACC2X: begin
              next_xl = acc;
              fin     = 1'b1;
            end
            `CST_OP_X2ACC: begin
              next_acc = xl;
              fin      = 1'b1;
            end
            `CST_OP_WAIT: begin
              next_ccr[`CST_CCR_I] = 1'b0;
              next_halted          = 1'b1;
              next_state           = st_halt;
            end
            `CST_OP_SWTRAP: begin
              // PC already points past the opcode here
              next_mem_addr  = sp;
              next_mem_wdata = pc[7:0];
              next_mem_we    = 1'b1;
              next_sp        = sp - 16'h0001;
              next_state     = st_exec;
            end
            `CST_OP_TAP, `CST_OP_SP2PAIR, `CST_OP_PAIR2SP: begin
              next_state = st_exec;
            end
            `CST_OP_TEST_IX: begin
              next_mem_addr = hx;
              next_state    = st_exec;
            end
            `CST_OP_TEST_DIR, `CST_OP_TEST_IX1, `CST_OP_LDA_ABS, `CST_OP_LDA_OFS16,
            `CST_OP_CBEQ_IX1P, `CST_OP_BRSET0, `CST_OP_BRCLR0,
            `CST_OP_MOV_DIXP, `CST_OP_MOV_IXPD, `CST_OP_MOV_IMMD: begin
              opf        = 1'b1;
              next_state = st_exec;
            end
            default: begin
              // Opcodes outside this slice retire as one-cycle no-ops
              fin = 1'b1;
            end
          endcase
        end
      end
      st_exec: begin
        next_step = step + 4'd1;
        case (opc)
          `CST_OP_SWTRAP: begin
            case (step)
              4'd1, 4'd2, 4'd3, 4'd4: begin
                next_mem_addr = sp;
                next_mem_we   = 1'b1;
                next_sp       = sp - 16'h0001;
                case (step)
                  4'd1:    next_mem_wdata = pc[15:8];
                  4'd2:    next_mem_wdata = xl;
                  4'd3:    next_mem_wdata = acc;
                  default: next_mem_wdata = flag_register;
                endcase
              end
              4'd5: begin
                next_ccr[`CST_CCR_I] = 1'b1;
                next_mem_addr        = `CST_VEC_HI;
              end
              4'd6: begin
                next_tmp      = mem_rdata_in;
                next_mem_addr = `CST_VEC_LO;
              end
              4'd7: next_pc = {tmp, mem_rdata_in};
              default: fin = 1'b1;
            endcase
          end
          `CST_OP_TAP: begin
            next_ccr = acc | `CST_CCR_ONES;
            fin      = 1'b1;
          end
          `CST_OP_SP2PAIR: begin
            {next_xh, next_xl} = sp + 16'h0001;
            fin                = 1'b1;
          end
          `CST_OP_PAIR2SP: begin
            next_sp = hx - 16'h0001;
            fin     = 1'b1;
          end
          `CST_OP_TEST_IX: begin
            set_nz = 1'b1;
            fin    = 1'b1;
          end
          `CST_OP_TEST_DIR, `CST_OP_TEST_IX1: begin
            if (step == 4'd1) begin
              next_mem_addr = (opc == `CST_OP_TEST_DIR) ?
                              {`CST_ZERO_PAGE, mem_rdata_in} : idx_sum;
            end else begin
              set_nz = 1'b1;
              fin    = 1'b1;
            end
          end
          `CST_OP_LDA_ABS, `CST_OP_LDA_OFS16: begin
            case (step)
              4'd1: begin
                next_tmp = mem_rdata_in;
                opf      = 1'b1;
              end
              4'd2: begin
                next_mem_addr = (opc == `CST_OP_LDA_ABS) ?
                                {tmp, mem_rdata_in} : idx_sum;
              end
              default: begin
                next_acc = mem_rdata_in;
                set_nz   = 1'b1;
                fin      = 1'b1;
              end
            endcase
          end
          `CST_OP_CBEQ_IX1P: begin
            case (step)
              4'd1: next_mem_addr = idx_sum;
              4'd2: begin
                next_tmp           = mem_rdata_in;
                {next_xh, next_xl} = hx + 16'h0001;
                opf                = 1'b1;
              end
              default: begin
                taken = (acc == tmp);
                fin   = 1'b1;
              end
            endcase
          end
          `CST_OP_BRSET0, `CST_OP_BRCLR0: begin
            case (step)
              4'd1: next_mem_addr = {`CST_ZERO_PAGE, mem_rdata_in};
              4'd2: begin
                next_tmp = mem_rdata_in;
                opf      = 1'b1;
              end
              default: begin
                next_ccr[`CST_CCR_C] = tmp[0];
                taken = (tmp[0] == (opc == `CST_OP_BRSET0));
                fin   = 1'b1;
              end
            endcase
          end
          `CST_OP_MOV_DIXP, `CST_OP_MOV_IXPD, `CST_OP_MOV_IMMD: begin
            case (step)
              4'd1: begin
                next_tmp = mem_rdata_in;
                if (opc == `CST_OP_MOV_DIXP) begin
                  next_mem_addr = {`CST_ZERO_PAGE, mem_rdata_in};
                end else if (opc == `CST_OP_MOV_IXPD) begin
                  next_mem_addr      = hx;
                  {next_xh, next_xl} = hx + 16'h0001;
                end else begin
                  opf = 1'b1;
                end
              end
              4'd2: begin
                next_mem_we = 1'b1;
                set_nz      = 1'b1;
                case (opc)
                  `CST_OP_MOV_DIXP: begin
                    next_mem_addr      = hx;
                    next_mem_wdata     = mem_rdata_in;
                    {next_xh, next_xl} = hx + 16'h0001;
                  end
                  `CST_OP_MOV_IXPD: begin
                    next_mem_addr  = {`CST_ZERO_PAGE, tmp};
                    next_mem_wdata = mem_rdata_in;
                  end
                  default: begin
                    next_mem_addr  = {`CST_ZERO_PAGE, mem_rdata_in};
                    next_mem_wdata = tmp;
                  end
                endcase
              end
              default: fin = 1'b1;
            endcase
          end
          default: fin = 1'b1;
        endcase
      end
      st_halt: begin
        // Everything but the wake-up test stays frozen
        if (irq_in) begin
          next_halted = 1'b0;
          fin         = 1'b1;
        end
      end
      default: next_state = st_decode;
    endcase
    if (set_nz) begin
      next_ccr[`CST_CCR_V] = 1'b0;
      next_ccr[`CST_CCR_N] = nz_n;
      next_ccr[`CST_CCR_Z] = nz_z;
    end
    if (taken) begin
      next_pc = br_sum;
    end
    if (opf || fin) begin
      next_mem_addr = next_pc;
      next_pc       = next_pc + 16'h0001;
    end
    if (fin) begin
      next_state  = st_decode;
      next_strobe = 1'b1;
      next_pre    = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state     <= st_decode;
      step      <= 4'h0;
      opc       <= 8'h00;
      pre       <= 1'b0;
      tmp       <= 8'h00;
      acc       <= 8'h00;
      xl        <= 8'h00;
      xh        <= 8'h00;
      sp        <= `CST_SP_RST;
      pc        <= `CST_PC_RST + 16'h0001;
      flag_register       <= `CST_CCR_RST;
      mem_addr  <= `CST_PC_RST;
      mem_wdata <= 8'h00;
      mem_we    <= 1'b0;
      strobe    <= 1'b1;
      halted    <= 1'b0;
    end else begin
      state     <= next_state;
      step      <= next_step;
      opc       <= next_opc;
      pre       <= next_pre;
      tmp       <= next_tmp;
      acc       <= next_acc;
      xl        <= next_xl;
      xh        <= next_xh;
      sp        <= next_sp;
      pc        <= next_pc;
      flag_register       <= next_ccr;
      mem_addr  <= next_mem_addr;
      mem_wdata <= next_mem_wdata;
      mem_we    <= next_mem_we;
      strobe    <= next_strobe;
      halted    <= next_halted;
    end
  end

  assign mem_addr_out      = mem_addr;
  assign mem_wdata_out     = mem_wdata;
  assign mem_we_out        = mem_we;
  assign opcode_strobe_out = strobe;
  assign halted_out        = halted;
  assign acc_out           = acc;
  assign x_out             = xl;
  assign h_out             = xh;
  assign sp_out            = sp;
  assign pc_out            = pc;
  assign ccr_out           = flag_register;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  logic dec_ok;
  assign dec_ok = strobe && !pre && (state == st_decode);

  a_trap_length: assert property (dec_ok && mem_rdata_in == `CST_OP_SWTRAP |->
    ##1 !strobe[*8] ##1 strobe) else $error("trap length wrong");
  a_trap_pushes: assert property (dec_ok && mem_rdata_in == `CST_OP_SWTRAP |->
    ##1 mem_we_out[*5] ##1 !mem_we_out) else $error("trap push count wrong");
  a_trap_mask: assert property (dec_ok && mem_rdata_in == `CST_OP_SWTRAP |->
    ##9 ccr_out[`CST_CCR_I] &&
    ((ccr_out | `CST_CCR_IMASK) == ($past(ccr_out, 9) | `CST_CCR_IMASK)))
    else $error("trap flags wrong");
  a_wait_mask: assert property (dec_ok && mem_rdata_in == `CST_OP_WAIT |=>
    !ccr_out[`CST_CCR_I] && halted_out) else $error("wait entry wrong");
  a_wait_hold: assert property (halted_out && !irq_in |=>
    halted_out && $stable(pc_out) && !strobe) else $error("wait did not hold");
  a_test_flags: assert property (dec_ok && mem_rdata_in == `CST_OP_TEST_A |=>
    !ccr_out[`CST_CCR_V] && (ccr_out[`CST_CCR_Z] == ($past(acc_out) == 8'h00)) &&
    (ccr_out[`CST_CCR_C] == $past(ccr_out[`CST_CCR_C]))) else $error("test flags wrong");
  a_test_dir_len: assert property (dec_ok && mem_rdata_in == `CST_OP_TEST_DIR |->
    ##1 !strobe[*2] ##1 strobe) else $error("direct test length wrong");
  a_test_sp_len: assert property ((dec_ok && mem_rdata_in == `CST_OP_PREFIX) ##1
    (strobe && mem_rdata_in == `CST_OP_TEST_IX1) |-> ##1 !strobe[*2] ##1 strobe)
    else $error("stack test length wrong");
  a_ofs16_addr: assert property (dec_ok && mem_rdata_in == `CST_OP_LDA_OFS16 |->
    ##3 mem_addr_out == ({h_out, x_out} +
    {$past(mem_rdata_in, 2), $past(mem_rdata_in, 1)})) else $error("offset16 address wrong");
  a_abs_addr: assert property (dec_ok && mem_rdata_in == `CST_OP_LDA_ABS |->
    ##3 mem_addr_out == {$past(mem_rdata_in, 2), $past(mem_rdata_in, 1)})
    else $error("extended address wrong");
  a_postinc_pair: assert property (dec_ok && mem_rdata_in == `CST_OP_CBEQ_IX1P |->
    ##3 {h_out, x_out} == $past({h_out, x_out}, 3) + 16'h0001)
    else $error("post increment wrong");
  a_mov_immd: assert property (dec_ok && mem_rdata_in == `CST_OP_MOV_IMMD |->
    ##3 mem_we_out && mem_wdata_out == $past(mem_rdata_in, 2) &&
    mem_addr_out == {`CST_ZERO_PAGE, $past(mem_rdata_in, 1)}) else $error("move wrong");
  a_brbit_len: assert property (dec_ok && mem_rdata_in == `CST_OP_BRSET0 |->
    ##1 !strobe[*3] ##1 strobe) else $error("bit branch length wrong");
  a_sp_pair_move: assert property (dec_ok && mem_rdata_in == `CST_OP_SP2PAIR |->
    ##2 strobe && {h_out, x_out} == $past(sp_out, 2) + 16'h0001)
    else $error("stack to pair move wrong");

  c_trap: cover property (dec_ok && mem_rdata_in == `CST_OP_SWTRAP ##9 strobe);
  c_wake: cover property (halted_out ##1 irq_in ##1 strobe);
  c_cbeq_taken: cover property (state == st_exec && opc == `CST_OP_CBEQ_IX1P && taken);
  c_prefixed: cover property (strobe && pre && mem_rdata_in == `CST_OP_TEST_IX1);
endmodule : cst_core

// ### hw/cst_nz_flags.sv
`timescale 1ns/10ps
module cst_nz_flags #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] val_in,
  output logic              neg_out,
  output logic              zero_out
);
  logic [W-1:0] diff;
  // Subtracting zero never borrows, so only sign and zero matter
  assign diff     = val_in - {W{1'b0}};
  assign neg_out  = diff[W-1];
  assign zero_out = (diff == {W{1'b0}});
endmodule : cst_nz_flags

// ### shared/cst_cfg.svh
`ifndef CST_CFG_SVH
`define CST_CFG_SVH
// ---------------------------------------------------------------
// Opcodes
// ---------------------------------------------------------------
`define CST_OP_SWTRAP    8'h83
`define CST_OP_TAP       8'h84
`define CST_OP_FLG2ACC   8'h85
`define CST_OP_PAIR2SP   8'h94
`define CST_OP_SP2PAIR   8'h95
`define CST_OP_ACC2X     8'h97
`define CST_OP_X2ACC     8'h9F
`define CST_OP_WAIT      8'h8F
`define CST_OP_PREFIX    8'h9E
`define CST_OP_TEST_DIR  8'h3D
`define CST_OP_TEST_A    8'h4D
`define CST_OP_TEST_X    8'h5D
`define CST_OP_TEST_IX1  8'h6D
`define CST_OP_TEST_IX   8'h7D
`define CST_OP_LDA_ABS   8'hC6
`define CST_OP_LDA_OFS16 8'hD6
`define CST_OP_CBEQ_IX1P 8'h61
`define CST_OP_BRSET0    8'h00
`define CST_OP_BRCLR0    8'h01
`define CST_OP_MOV_DIXP  8'h5E
`define CST_OP_MOV_IMMD  8'h6E
`define CST_OP_MOV_IXPD  8'h7E
// ---------------------------------------------------------------
// Flag register layout and reset values
// ---------------------------------------------------------------
`define CST_CCR_V        7
`define CST_CCR_I        3
`define CST_CCR_N        2
`define CST_CCR_Z        1
`define CST_CCR_C        0
`define CST_CCR_IMASK    8'h08
`define CST_CCR_ONES     8'h60
`define CST_CCR_RST      8'h68
`define CST_SP_RST       16'h00FF
`define CST_PC_RST       16'h0000
`define CST_VEC_HI       16'hFFFC
`define CST_VEC_LO       16'hFFFD
`define CST_ZERO_PAGE    8'h00
`endif

// ### shared/cst_pkg.sv
package cst_pkg;
  typedef enum logic [1:0] {
    st_decode = 2'b00,
    st_exec   = 2'b01,
    st_halt   = 2'b10
  } cst_state_t;
endpackage : cst_pkg

// ### sim/test_cst_core.sv
`timescale 1ns/10ps
module test_cst_core;
  import cst_pkg::*;
  logic        clk_in;
  logic        rst_n_in;
  logic [7:0]  mem_rdata_in;
  logic        irq_in;
  logic [15:0] mem_addr_out;
  logic [7:0]  mem_wdata_out;
  logic        mem_we_out;
  logic        opcode_strobe_out;
  logic        halted_out;
  logic [7:0]  acc_out;
  logic [7:0]  x_out;
  logic [7:0]  h_out;
  logic [15:0] sp_out;
  logic [15:0] pc_out;
  logic [7:0]  ccr_out;
  logic [7:0]  mem [0:65535];
  logic [7:0]  r [0:9];
  logic [7:0]  ea;
  logic [7:0]  ec;
  logic [15:0] hx;
  logic        irq_rnd;
  int          errors;
  int          comparisons;
  int          cyc;

  cst_core i_cst_core (
    .clk_in            (clk_in),
    .rst_n_in          (rst_n_in),
    .mem_rdata_in      (mem_rdata_in),
    .irq_in            (irq_in),
    .mem_addr_out      (mem_addr_out),
    .mem_wdata_out     (mem_wdata_out),
    .mem_we_out        (mem_we_out),
    .opcode_strobe_out (opcode_strobe_out),
    .halted_out        (halted_out),
    .acc_out           (acc_out),
    .x_out             (x_out),
    .h_out             (h_out),
    .sp_out            (sp_out),
    .pc_out            (pc_out),
    .ccr_out           (ccr_out)
  );

  // ---------------------------------------------------------------
  // Memory, clock, noise on the interrupt line, timeout
  // ---------------------------------------------------------------
  assign mem_rdata_in = mem[mem_addr_out];
  always @(posedge clk_in) begin
    if (mem_we_out === 1'b1) mem[mem_addr_out] <= mem_wdata_out;
  end
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  // Request must be ignored while the core is running
  always @(posedge clk_in) begin
    #2;
    if (irq_rnd) irq_in = 1'($urandom_range(0, 1));
  end
  always @(posedge clk_in) begin
    cyc++;
    if (cyc > 3000) begin
      errors++;
      finish_test();
    end
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] nz(input logic [7:0] c, input logic [7:0] v);
    return (c & 8'h79) | {5'h00, v[7], v == 8'h00, 1'b0};
  endfunction : nz

  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic put(input logic [15:0] a, input logic [7:0] b [$]);
    foreach (b[i]) mem[a + 16'(i)] = b[i];
  endtask : put

  // Called at the negedge of an opcode cycle; ends at the next one
  task automatic step(input int len, input logic [15:0] nxt, input bit pfx = 1'b0);
    int n;
    n = 0;
    if (pfx) begin
      @(negedge clk_in);
      n = 1;
    end
    do begin
      @(negedge clk_in);
      n++;
    end while (opcode_strobe_out !== 1'b1 && n < 30);
    chk("cycles", 16'(len), 16'(n));
    chk("opcode_addr", nxt, mem_addr_out);
  endtask : step

  task automatic regs();
    chk("acc", {8'h00, ea}, {8'h00, acc_out});
    chk("ccr", {8'h00, ec}, {8'h00, ccr_out});
    chk("hx", hx, {h_out, x_out});
  endtask : regs

  task automatic finish_test();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  // ---------------------------------------------------------------
  // Program and main sequence
  // ---------------------------------------------------------------
  initial begin
    errors = 0;
    comparisons = 0;
    cyc = 0;
    rst_n_in = 1'b0;
    irq_in = 1'b0;
    irq_rnd = 1'b1;
    void'($urandom(85));
    foreach (r[i]) r[i] = 8'($urandom);
    r[0] = 8'h00;
    r[1] = 8'h80;
    for (int a = 0; a < 65536; a++) mem[a] = 8'h9D;
    put(16'h0000, '{8'hC6, 8'h01, 8'h30, 8'h4D, 8'h97, 8'h5D, 8'h3D, 8'h80, 8'h85});
    put(16'h0009, '{8'hC6, 8'h01, 8'h31, 8'h84, 8'h9F, 8'h95, 8'hD6, 8'h00, 8'h20});
    put(16'h0012, '{8'h6D, 8'h10, 8'h7D, 8'h9E, 8'h6D, 8'h21, 8'h61, 8'h20, 8'h02});
    put(16'h001D, '{8'h94, 8'h5E, 8'h81, 8'h7E, 8'h82, 8'h6E, r[6], 8'h83});
    put(16'h0025, '{8'h00, 8'h84, 8'h01, 8'h9D, 8'h83});
    put(16'hFFFC, '{8'h02, 8'h00, 8'h8F, 8'h9D});
    mem[16'h0200] = 8'h8F;
    {mem[16'h0130], mem[16'h0080], mem[16'h0120], mem[16'h0110]} = {r[0], r[1], r[2], r[3]};
    {mem[16'h0081], mem[16'h0102], mem[16'h0084], mem[16'h0131]} = {r[4], r[5], r[7], r[8]};
    mem[16'h0100] = r[9];
    repeat (8) @(posedge clk_in);
    #2 rst_n_in = 1'b1;
    @(negedge clk_in);
    chk("opcode_addr", 16'h0000, mem_addr_out);
    {ea, ec, hx} = {8'h00, 8'h68, 16'h0000};
    step(4, 16'h0003); ea = r[0]; ec = nz(ec, r[0]); regs();
    step(1, 16'h0004); regs();
    step(1, 16'h0005); hx = {8'h00, r[0]}; regs();
    step(1, 16'h0006); regs();
    step(3, 16'h0008); ec = nz(ec, r[1]); regs();
    step(1, 16'h0009); ea = ec; regs();
    step(4, 16'h000C); ea = r[8]; ec = nz(ec, r[8]); regs();
    step(2, 16'h000D); ec = r[8] | 8'h60; regs();
    step(1, 16'h000E); ea = r[0]; regs();
    step(2, 16'h000F); hx = 16'h0100; regs();
    step(4, 16'h0012); ea = r[2]; ec = nz(ec, r[2]); regs();
    step(3, 16'h0014); ec = nz(ec, r[3]); regs();
    step(2, 16'h0015); ec = nz(ec, r[9]); regs();
    step(4, 16'h0018, 1'b1); ec = nz(ec, r[2]); regs();
    step(4, 16'h001D); hx = 16'h0101; regs();
    step(2, 16'h001E); chk("sp", 16'h0100, sp_out);
    step(4, 16'h0020); hx = 16'h0102; ec = nz(ec, r[4]); regs();
    step(4, 16'h0022); hx = 16'h0103; ec = nz(ec, r[5]); regs();
    irq_rnd = 1'b0;
    irq_in = 1'b0;
    step(4, 16'h0025); ec = nz(ec, r[6]); regs();
    step(4, r[7][0] ? 16'h0029 : 16'h0028); ec = {ec[7:1], r[7][0]}; regs();
    if (!r[7][0]) step(1, 16'h0029);
    step(9, 16'h0200);
    chk("sp", 16'h00FB, sp_out);
    chk("stack_pc", 16'h2A00, {mem[16'h0100], mem[16'h00FF]});
    chk("stack_x_a", {8'h03, ea}, {mem[16'h00FE], mem[16'h00FD]});
    chk("stack_ccr", {8'h00, ec}, {8'h00, mem[16'h00FC]});
    ec = ec | 8'h08;
    regs();
    chk("moved", {r[4], r[5]}, {mem[16'h0101], mem[16'h0082]});
    chk("moved_imm", {8'h00, r[6]}, {8'h00, mem[16'h0083]});
    @(negedge clk_in);
    ec = ec & 8'hF7;
    chk("halted", 16'h0001, {15'h0000, halted_out});
    regs();
    begin
      int bad;
      logic [15:0] pc0;
      bad = 0;
      pc0 = pc_out;
      repeat (12) begin
        @(negedge clk_in);
        if (opcode_strobe_out !== 1'b0 || mem_we_out !== 1'b0 || pc_out !== pc0) bad++;
      end
      chk("halt_stall", 16'h0000, 16'(bad));
    end
    @(posedge clk_in);
    #2 irq_in = 1'b1;
    step(2, 16'h0201);
    chk("halted", 16'h0000, {15'h0000, halted_out});
    regs();
    @(posedge clk_in);
    #2 irq_in = 1'b0;
    finish_test();
  end
endmodule : test_cst_core
